// *** common/uart_flow_ir_defs.svh ***
/*
 Constants for the flow-control, infrared and interrupt-flag block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef UART_FLOW_IR_DEFS_SVH
`define UART_FLOW_IR_DEFS_SVH
`define PIN_USE_RTS_ONLY   2'b01
`define PIN_USE_RTS_CTS    2'b10
`define PIN_USE_BCLK       2'b11
`define TICKS_PER_BIT      5'd16
`define TICK_LAST          4'hf
`define IR_PULSE_START     4'h7
`define IR_PULSE_END       4'h9
`define DEC_HOLD           4'hf
`define FIFO_DEPTH         16
`define FIFO_ROOM_MIN      5'd2
`define RXSEL_ANY          2'b00
`define RXSEL_HALF         2'b01
`define RXSEL_3Q           2'b10
`define FILL_HALF          5'd8
`define FILL_3Q            5'd12
`define TXSEL_ROOM         2'b00
`define TXSEL_DRAINED      2'b01
`define TXSEL_EMPTY        2'b10
`define VOTE_BEGIN         4'h7
`define VOTE_END           4'h9
`endif

// *** common/uart_flow_ir_pkg.sv ***
/*
 Types for the flow-control and infrared block.
 Needs no include; only the design file reads the defines header.
*/
`default_nettype none
package uart_flow_ir_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_HELD, TX_SEND} tx_state_t;
endpackage
`default_nettype wire

// *** logic/uart_flow_fifo.sv ***
/*
 Receive FIFO, valid/ready on both sides, width and depth parameters.
 Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
module uart_flow_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   // Fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // Full only at the depth itself; an AW-bit cast of the depth would wrap to zero
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
   assign level     = cnt_q;

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_q] <= in_data;
      if (srst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// *** logic/uart_flow_ir.sv ***
/*
 Flow control, infrared codec and interrupt flags of a UART.
 Assumes a one-cycle 16x baud tick, a core that offers one word to send
 and one received character at a time, and synchronous pins.
*/
`default_nettype none
`include "uart_flow_ir_defs.svh"
module uart_flow_ir
   import uart_flow_ir_pkg::*;
(
   // Clock and reset
   input  wire logic       MCLK,
   input  wire logic       SRST,
   // Configuration
   input  wire logic       MODULE_ON,
   input  wire logic [1:0] PIN_USE_SELECT,
   input  wire logic       HANDSHAKE_STYLE,
   input  wire logic       INFRARED_ENABLE,
   input  wire logic       IR_TX_POLARITY,
   input  wire logic [1:0] RX_IRQ_SELECT,
   input  wire logic [1:0] TX_IRQ_SELECT,
   // Interrupt enables and clears
   input  wire logic       RX_IRQ_ENABLE,
   input  wire logic       TX_IRQ_ENABLE,
   input  wire logic       ERR_IRQ_ENABLE,
   input  wire logic       RX_IRQ_CLEAR,
   input  wire logic       TX_IRQ_CLEAR,
   input  wire logic       ERR_IRQ_CLEAR,
   // Core timing
   input  wire logic       BAUD16_TICK,
   // Transmit data from the core
   input  wire logic       TX_WORD_VALID,
   input  wire logic [7:0] TX_WORD,
   output logic            TX_WORD_READY,
   // Received characters from the core
   input  wire logic       RX_CHAR_VALID,
   input  wire logic [7:0] RX_CHAR,
   input  wire logic       RX_SHIFTING,
   input  wire logic       PARITY_FAULT,
   input  wire logic       FRAMING_FAULT,
   // Receive FIFO drain
   output logic            RX_DATA_VALID,
   input  wire logic       RX_DATA_READY,
   output logic [7:0]      RX_DATA,
   // Status
   output logic            SHIFTER_EMPTY,
   output logic            OVERRUN_FLAG,
   output logic            RX_DECODED,
   output logic            RX_VOTED_BIT,
   output logic            RX_IRQ_FLAG,
   output logic            TX_IRQ_FLAG,
   output logic            ERR_IRQ_FLAG,
   output logic            IRQ,
   // Pins
   input  wire logic       TX_PERMIT_IN,
   input  wire logic       SERIAL_IN,
   output logic            SERIAL_OUT,
   output logic            RX_READY_OUT,
   output logic            RX_READY_OE,
   output logic            BAUD16_CLOCK_OUT
);
   tx_state_t   st_q;
   logic [7:0]  shreg_q;
   logic [3:0]  bitn_q;
   logic [3:0]  tick_q;
   logic        txbit_q;
   logic        ser_q;
   logic        irq_q, rxf_q, txf_q, erf_q, ovr_q;
   logic        rts_q, rtsoe_q, bclk_q, rdv_q;
   logic [7:0]  rd_q;
   logic        rin_q;
   logic [3:0]  dec_cnt_q;
   logic        dec_q;
   logic [3:0]  rx_tick_q;
   logic [1:0]  votes_q;
   logic        vote_q;
   logic [4:0]  level;
   logic        f_in_ready, f_out_valid;
   logic [7:0]  f_out_data;

   // Permit only counts when pin-use selects it
   wire permit_used = (PIN_USE_SELECT == `PIN_USE_RTS_CTS);
   wire permit_ok   = !permit_used || !TX_PERMIT_IN;
   wire bit_start   = BAUD16_TICK && (tick_q == 4'h0);
   wire load_word   = TX_WORD_VALID && (st_q == TX_IDLE);
   // Bit count stays at nine in idle after a word, so the state must qualify it
   wire word_done   = BAUD16_TICK && (tick_q == `TICK_LAST) && (bitn_q == 4'h9) &&
                      (st_q == TX_SEND);
   wire shifter_emp = (st_q == TX_IDLE);
   wire rts_active  = (PIN_USE_SELECT == `PIN_USE_RTS_ONLY) || permit_used;
   wire fifo_room   = (5'(`FIFO_DEPTH) - level) >= `FIFO_ROOM_MIN;
   wire rts_flow    = !fifo_room || RX_SHIFTING;
   wire rts_level   = HANDSHAKE_STYLE ? shifter_emp : rts_flow;
   wire ir_pulse    = !txbit_q && (tick_q >= `IR_PULSE_START) && (tick_q <= `IR_PULSE_END);
   // Idle follows polarity; a pulse toggles away from it
   wire ir_out      = IR_TX_POLARITY ^ ir_pulse;
   wire ser_next    = INFRARED_ENABLE ? ir_out : txbit_q;
   wire rin_fall    = rin_q && !SERIAL_IN;
   wire rx_src      = INFRARED_ENABLE ? dec_q : SERIAL_IN;
   wire push        = RX_CHAR_VALID && f_in_ready;
   wire overrun_ev  = RX_CHAR_VALID && !f_in_ready;
   wire in_vote     = (rx_tick_q >= `VOTE_BEGIN) && (rx_tick_q <= `VOTE_END);
   wire rx_ev       = push && ((RX_IRQ_SELECT == `RXSEL_ANY) ||
                      (RX_IRQ_SELECT == `RXSEL_HALF && level + 5'd1 >= `FILL_HALF) ||
                      (RX_IRQ_SELECT[1] && level + 5'd1 >= `FILL_3Q));
   wire tx_ev       = (TX_IRQ_SELECT == `TXSEL_ROOM)    ? load_word :
                      (TX_IRQ_SELECT == `TXSEL_DRAINED) ? word_done :
                      (TX_IRQ_SELECT == `TXSEL_EMPTY)   ? (load_word || word_done) : 1'b0;
   wire err_ev      = PARITY_FAULT || FRAMING_FAULT || overrun_ev;

   assign TX_WORD_READY    = (st_q == TX_IDLE);
   assign SHIFTER_EMPTY    = !ser_q ? shifter_emp : shifter_emp;
   assign SERIAL_OUT       = ser_q;
   assign RX_READY_OUT     = rts_q;
   assign RX_READY_OE      = rtsoe_q;
   assign BAUD16_CLOCK_OUT = bclk_q;
   assign OVERRUN_FLAG     = ovr_q;
   assign RX_IRQ_FLAG      = rxf_q;
   assign TX_IRQ_FLAG      = txf_q;
   assign ERR_IRQ_FLAG     = erf_q;
   assign IRQ              = irq_q;
   assign RX_DECODED       = dec_q;
   assign RX_VOTED_BIT     = vote_q;
   assign RX_DATA_VALID    = f_out_valid;
   assign RX_DATA          = f_out_data;

   // Transmitter: word waits in shifter until permit sampled low
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         st_q    <= TX_IDLE;
         shreg_q <= 8'h00;
         bitn_q  <= 4'h0;
         tick_q  <= 4'h0;
         txbit_q <= 1'b1;
      end
      else
      begin
         if (BAUD16_TICK)
            tick_q <= tick_q + 4'h1;
         case (st_q)
            TX_IDLE:
               if (load_word)
               begin
                  shreg_q <= TX_WORD;
                  st_q    <= TX_HELD;
               end
            TX_HELD:
               if (bit_start && permit_ok)
               begin
                  st_q    <= TX_SEND;
                  bitn_q  <= 4'h0;
                  txbit_q <= 1'b0;
               end
            TX_SEND:
               if (BAUD16_TICK && tick_q == `TICK_LAST)
               begin
                  if (bitn_q == 4'h9)
                  begin
                     st_q    <= TX_IDLE;
                     txbit_q <= 1'b1;
                  end
                  else
                  begin
                     bitn_q  <= bitn_q + 4'h1;
                     txbit_q <= (bitn_q == 4'h8) ? 1'b1 : shreg_q[bitn_q[2:0]];
                  end
               end
            default:
               st_q <= TX_IDLE;
         endcase
      end
   end

   // Pins driven from flops
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         ser_q   <= 1'b1;
         rts_q   <= 1'b1;
         rtsoe_q <= 1'b0;
         bclk_q  <= 1'b0;
      end
      else
      begin
         ser_q   <= ser_next;
         rts_q   <= rts_level;
         rtsoe_q <= rts_active;
         bclk_q  <= MODULE_ON && (PIN_USE_SELECT == `PIN_USE_BCLK) &&
                    (tick_q[3] ^ BAUD16_TICK);
      end
   end

   // Decoder: low for 16 ticks per falling edge of SERIAL_IN; polarity not used
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         rin_q     <= 1'b1;
         dec_cnt_q <= 4'h0;
         dec_q     <= 1'b1;
      end
      else
      begin
         rin_q <= SERIAL_IN;
         if (rin_fall)
         begin
            dec_cnt_q <= `DEC_HOLD;
            dec_q     <= 1'b0;
         end
         else if (BAUD16_TICK && !dec_q)
         begin
            if (dec_cnt_q == 4'h0)
               dec_q <= 1'b1;
            else
               dec_cnt_q <= dec_cnt_q - 4'h1;
         end
      end
   end

   // Three-sample majority around the bit centre rejects one-tick glitches
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         rx_tick_q <= 4'h0;
         votes_q   <= 2'b00;
         vote_q    <= 1'b1;
      end
      else if (BAUD16_TICK)
      begin
         rx_tick_q <= rx_tick_q + 4'h1;
         if (in_vote)
            votes_q <= votes_q + 2'(rx_src);
         if (rx_tick_q == `VOTE_END)
         begin
            vote_q  <= (votes_q + 2'(rx_src)) >= 2'd2;
            votes_q <= 2'b00;
         end
      end
   end

   // Sticky flags: a set in the clearing cycle wins
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         rxf_q <= 1'b0;
         txf_q <= 1'b0;
         erf_q <= 1'b0;
         ovr_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         rxf_q <= rx_ev  || (rxf_q && !RX_IRQ_CLEAR);
         txf_q <= tx_ev  || (txf_q && !TX_IRQ_CLEAR);
         erf_q <= err_ev || (erf_q && !ERR_IRQ_CLEAR);
         ovr_q <= overrun_ev || (ovr_q && !ERR_IRQ_CLEAR);
         irq_q <= (rxf_q && RX_IRQ_ENABLE) || (txf_q && TX_IRQ_ENABLE) ||
                  (erf_q && ERR_IRQ_ENABLE);
      end
   end

   uart_flow_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) rx_fifo (
      .clk       (MCLK),
      .srst      (SRST),
      .in_valid  (RX_CHAR_VALID),
      .in_ready  (f_in_ready),
      .in_data   (RX_CHAR),
      .out_valid (f_out_valid),
      .out_ready (RX_DATA_READY),
      .out_data  (f_out_data),
      .level     (level)
   );

   held_until_permit_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      (st_q == TX_HELD && permit_used && TX_PERMIT_IN) |=> st_q != TX_SEND)
      else $error("Transmission started while permit high");
   start_on_tick_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      (st_q == TX_HELD) ##1 (st_q == TX_SEND) |-> $past(bit_start))
      else $error("Transmission started off the first tick");
   rts_drive_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      ##1 (RX_READY_OE == $past(rts_active)))
      else $error("Receive-ready enable wrong for pin-use");
   rts_room_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      (!HANDSHAKE_STYLE && level >= 5'd15) |=> RX_READY_OUT)
      else $error("Receive-ready low without room for two");
   rts_simplex_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      (HANDSHAKE_STYLE && st_q != TX_IDLE) |=> !RX_READY_OUT)
      else $error("Simplex receive-ready not asserted while busy");
   ir_one_bit_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      (INFRARED_ENABLE && txbit_q) |=> SERIAL_OUT == $past(IR_TX_POLARITY))
      else $error("Encoder pulsed on a one bit");
   dec_fall_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      rin_fall |=> !RX_DECODED)
      else $error("Decoder missed falling edge");
   flag_sticky_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      (ERR_IRQ_FLAG && !ERR_IRQ_CLEAR) |=> ERR_IRQ_FLAG)
      else $error("Error flag dropped without clear");
   err_set_a:
      assert property (@(posedge MCLK) disable iff (SRST)
      (PARITY_FAULT || FRAMING_FAULT) |=> ERR_IRQ_FLAG)
      else $error("Error flag not set on fault");
endmodule
`default_nettype wire

// *** tb/remote_terminal.sv ***
/*
 Far-side model: remote terminal or data set on the permit and serial lines.
 Assumes the bench clock and 16x tick; it drives its pins just after a rising edge.
*/
`default_nettype none
module remote_terminal (
   // Clock and tick
   input  wire logic MCLK,
   input  wire logic BAUD16_TICK,
   // Request from the device
   input  wire logic RX_READY_OUT,
   // Pins toward the device
   output logic      TX_PERMIT_IN,
   output logic      SERIAL_IN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic auto_grant;
   int   grant_delay;
   int   wait_cnt;
   initial
   begin
      TX_PERMIT_IN = 1'b1;
      SERIAL_IN    = 1'b1;
      auto_grant   = 1'b0;
      grant_delay  = 300;
      wait_cnt     = 0;
   end
   // Slow data set: grants only after a long ready delay
   always @(posedge MCLK)
   begin
      if (auto_grant)
      begin
         wait_cnt <= (RX_READY_OUT === 1'b0) ? wait_cnt + 1 : 0;
         TX_PERMIT_IN <= !(RX_READY_OUT === 1'b0 && wait_cnt >= grant_delay);
      end
   end
   // Level set on a rising edge and held one clock before return, never a glitch
   task automatic set_permit(input logic lvl);
      @(posedge MCLK);
      TX_PERMIT_IN <= lvl;
      @(posedge MCLK);
   endtask
   // Normal-polarity light pulse of three ticks
   task automatic ir_pulse();
      int k;
      k = 0;
      @(posedge MCLK);
      SERIAL_IN <= 1'b0;
      while (k < 3)
      begin
         @(posedge MCLK);
         if (BAUD16_TICK === 1'b1) k++;
      end
      SERIAL_IN <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/*
 Self-checking bench for the flow-control, infrared and flag block.
 Assumes the design files and the far-side model compiled before it.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TICK_GAP = 2;
   localparam int BIT_CYC  = 16 * TICK_GAP;
   logic       MCLK, SRST, MODULE_ON, HANDSHAKE_STYLE, INFRARED_ENABLE, IR_TX_POLARITY;
   logic [1:0] PIN_USE_SELECT, RX_IRQ_SELECT, TX_IRQ_SELECT;
   logic       RX_IRQ_ENABLE, TX_IRQ_ENABLE, ERR_IRQ_ENABLE, RX_IRQ_CLEAR, TX_IRQ_CLEAR;
   logic       ERR_IRQ_CLEAR, BAUD16_TICK, TX_WORD_VALID, TX_WORD_READY, RX_CHAR_VALID;
   logic       RX_SHIFTING, PARITY_FAULT, FRAMING_FAULT, RX_DATA_VALID, RX_DATA_READY;
   logic [7:0] TX_WORD, RX_CHAR, RX_DATA;
   logic       SHIFTER_EMPTY, OVERRUN_FLAG, RX_DECODED, RX_VOTED_BIT, RX_IRQ_FLAG;
   logic       TX_IRQ_FLAG, ERR_IRQ_FLAG, IRQ, TX_PERMIT_IN, SERIAL_IN, SERIAL_OUT;
   logic       RX_READY_OUT, RX_READY_OE, BAUD16_CLOCK_OUT, tick_ph, b;
   logic [7:0] exp_q[$], act_q[$], data_q[$], e, a, w;
   int         errors, tests_run, n;

   uart_flow_ir dut (.MCLK, .SRST, .MODULE_ON, .PIN_USE_SELECT, .HANDSHAKE_STYLE,
      .INFRARED_ENABLE, .IR_TX_POLARITY, .RX_IRQ_SELECT, .TX_IRQ_SELECT, .RX_IRQ_ENABLE,
      .TX_IRQ_ENABLE, .ERR_IRQ_ENABLE, .RX_IRQ_CLEAR, .TX_IRQ_CLEAR, .ERR_IRQ_CLEAR,
      .BAUD16_TICK, .TX_WORD_VALID, .TX_WORD, .TX_WORD_READY, .RX_CHAR_VALID, .RX_CHAR,
      .RX_SHIFTING, .PARITY_FAULT, .FRAMING_FAULT, .RX_DATA_VALID, .RX_DATA_READY, .RX_DATA,
      .SHIFTER_EMPTY, .OVERRUN_FLAG, .RX_DECODED, .RX_VOTED_BIT, .RX_IRQ_FLAG, .TX_IRQ_FLAG,
      .ERR_IRQ_FLAG, .IRQ, .TX_PERMIT_IN, .SERIAL_IN, .SERIAL_OUT, .RX_READY_OUT,
      .RX_READY_OE, .BAUD16_CLOCK_OUT);
   remote_terminal far (.MCLK, .BAUD16_TICK, .RX_READY_OUT, .TX_PERMIT_IN, .SERIAL_IN);

   initial
   begin
      MCLK = 1'b0;
      forever #50 MCLK = ~MCLK;
   end
   // Tick every second clock keeps frames short
   always @(posedge MCLK)
   begin
      tick_ph <= ~tick_ph;
      BAUD16_TICK <= tick_ph;
   end
   // Results are compared off the edge, oldest note first
   always @(negedge MCLK)
      while (act_q.size() > 0)
      begin
         e = exp_q.pop_front();
         a = act_q.pop_front();
         tests_run++;
         if (a !== e)
         begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, a, e);
         end
      end

   task automatic note(input logic [7:0] ex, input logic [7:0] ac);
      exp_q.push_back(ex);
      act_q.push_back(ac);
   endtask
   task automatic stop_test();
      $display("Checks: %0d, mismatches: %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic timeout();
      errors++;
      $display("wrong value at %0t: wait ran out", $time);
      stop_test();
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge MCLK);
   endtask
   task automatic strobe(input logic [4:0] m);
      @(posedge MCLK);
      {RX_IRQ_CLEAR, TX_IRQ_CLEAR, ERR_IRQ_CLEAR, PARITY_FAULT, FRAMING_FAULT} <= m;
      @(posedge MCLK);
      {RX_IRQ_CLEAR, TX_IRQ_CLEAR, ERR_IRQ_CLEAR, PARITY_FAULT, FRAMING_FAULT} <= 5'h00;
   endtask
   task automatic send_word(input logic [7:0] d);
      int k;
      k = 0;
      @(posedge MCLK);
      {TX_WORD_VALID, TX_WORD} <= {1'b1, d};
      @(negedge MCLK);
      while (TX_WORD_READY !== 1'b1)
      begin
         k++;
         if (k > 4000) timeout();
         @(negedge MCLK);
      end
      @(posedge MCLK);
      TX_WORD_VALID <= 1'b0;
   endtask
   // Gated modes first prove the line stays idle, then release the permit
   task automatic do_tx(input int mode);
      logic [7:0] d, r;
      int k;
      d = 8'($urandom);
      k = 0;
      send_word(d);
      if (mode > 0)
      begin
         repeat (200)
         begin
            @(negedge MCLK);
            if (SERIAL_OUT !== 1'b1) k++;
         end
         note(8'h00, 8'(k));
         note(8'h00, 8'(SHIFTER_EMPTY));
         if (mode == 2) note(8'h00, 8'(RX_READY_OUT));
         if (mode == 2) far.grant_delay = 0;
         if (mode == 1) far.set_permit(1'b0);
      end
      k = 0;
      while (SERIAL_OUT !== 1'b0)
      begin
         @(negedge MCLK);
         k++;
         if (k > 4000) timeout();
      end
      repeat (BIT_CYC / 2) @(negedge MCLK);
      note(8'h00, 8'(SERIAL_OUT));
      for (int i = 0; i < 9; i++)
      begin
         repeat (BIT_CYC) @(negedge MCLK);
         r = {SERIAL_OUT, r[7:1]};
         if (i == 7) note(d, r);
      end
      note(8'h01, 8'(SERIAL_OUT));
      far.grant_delay = 300;
   endtask

   initial
   begin
      {MODULE_ON, HANDSHAKE_STYLE, INFRARED_ENABLE, IR_TX_POLARITY, PIN_USE_SELECT,
       RX_IRQ_SELECT, TX_IRQ_SELECT, RX_IRQ_ENABLE, TX_IRQ_ENABLE, ERR_IRQ_ENABLE,
       RX_IRQ_CLEAR, TX_IRQ_CLEAR, ERR_IRQ_CLEAR, BAUD16_TICK, TX_WORD_VALID, TX_WORD,
       RX_CHAR_VALID, RX_CHAR, RX_SHIFTING, PARITY_FAULT, FRAMING_FAULT, RX_DATA_READY,
       tick_ph} = '0;
      errors = 0;
      tests_run = 0;
      void'($urandom(32'h0cd42d16));
      SRST = 1'b1;
      repeat (4) @(posedge MCLK);
      SRST <= 1'b0;
      cyc(2);
      note(8'h04, {5'h00, SERIAL_OUT, RX_READY_OUT, RX_READY_OE});
      for (int s = 0; s < 4; s++)
      begin
         @(posedge MCLK);
         {PIN_USE_SELECT, MODULE_ON} <= {2'(s), 1'b1};
         cyc(3);
         note(8'(s == 1 || s == 2), 8'(RX_READY_OE));
      end
      for (int m = 1; m >= 0; m--)
      begin
         @(posedge MCLK);
         MODULE_ON <= 1'(m);
         cyc(3);
         n = 0;
         repeat (128)
         begin
            b = BAUD16_CLOCK_OUT;
            @(negedge MCLK);
            if (BAUD16_CLOCK_OUT !== b) n++;
         end
         note(8'(m), 8'(n > 0));
      end
      @(posedge MCLK);
      {PIN_USE_SELECT, TX_IRQ_ENABLE} <= 3'b001;
      do_tx(0);
      cyc(40);
      note(8'h03, {6'h00, TX_IRQ_FLAG, IRQ});
      @(posedge MCLK);
      {PIN_USE_SELECT, TX_IRQ_ENABLE, TX_IRQ_SELECT} <= 5'b10001;
      strobe(5'b01000);
      do_tx(1);
      cyc(40);
      note(8'h01, 8'(TX_IRQ_FLAG));
      strobe(5'b01000);
      cyc(100);
      note(8'h00, 8'(TX_IRQ_FLAG));
      far.set_permit(1'b1);
      @(posedge MCLK);
      HANDSHAKE_STYLE <= 1'b1;
      far.auto_grant <= 1'b1;
      cyc(3);
      note(8'h01, 8'(RX_READY_OUT));
      do_tx(2);
      cyc(40);
      note(8'h01, 8'(RX_READY_OUT));
      @(posedge MCLK);
      far.auto_grant <= 1'b0;
      {PIN_USE_SELECT, HANDSHAKE_STYLE, INFRARED_ENABLE} <= 4'b0001;
      for (int p = 0; p < 2; p++)
      begin
         @(posedge MCLK);
         IR_TX_POLARITY <= 1'(p);
         cyc(40);
         note(8'(p), 8'(SERIAL_OUT));
         w = 8'($urandom);
         send_word(w);
         n = 0;
         repeat (12 * BIT_CYC)
         begin
            @(negedge MCLK);
            if (SERIAL_OUT !== 1'(p)) n++;
         end
         note(8'((9 - $countones(w)) * 3 * TICK_GAP), 8'(n));
      end
      cyc(60);
      note(8'h01, 8'(RX_DECODED));
      n = 0;
      fork
         far.ir_pulse();
         repeat (100)
         begin
            @(negedge MCLK);
            if (RX_DECODED === 1'b0) n++;
         end
      join
      note(8'h01, 8'(n >= 30 && n <= 36));
      // Two close pulses keep the decoded line low across a whole vote window
      b = 1'b0;
      fork
         begin
            far.ir_pulse();
            far.ir_pulse();
         end
         repeat (120)
         begin
            @(negedge MCLK);
            if (RX_VOTED_BIT === 1'b0) b = 1'b1;
         end
      join
      note(8'h01, 8'(b));
      @(posedge MCLK);
      {PIN_USE_SELECT, INFRARED_ENABLE, RX_IRQ_SELECT, RX_SHIFTING} <= 6'b100011;
      strobe(5'b11100);
      cyc(3);
      note(8'h01, 8'(RX_READY_OUT));
      @(posedge MCLK);
      RX_SHIFTING <= 1'b0;
      cyc(3);
      note(8'h00, 8'(RX_READY_OUT));
      for (int k = 1; k <= 17; k++)
      begin
         w = 8'($urandom);
         if (k <= 16) data_q.push_back(w);
         @(posedge MCLK);
         {RX_CHAR_VALID, RX_CHAR} <= {1'b1, w};
         @(posedge MCLK);
         RX_CHAR_VALID <= 1'b0;
         cyc(3);
         if (k == 7 || k == 8) note(8'(k == 8), 8'(RX_IRQ_FLAG));
         if (k == 14 || k == 15) note(8'(k == 15), 8'(RX_READY_OUT));
      end
      note(8'h06, {5'h00, OVERRUN_FLAG, ERR_IRQ_FLAG, IRQ});
      @(posedge MCLK);
      RX_IRQ_ENABLE <= 1'b1;
      strobe(5'b00100);
      cyc(3);
      note(8'h01, {5'h00, OVERRUN_FLAG, ERR_IRQ_FLAG, IRQ});
      @(posedge MCLK);
      RX_DATA_READY <= 1'b1;
      n = 0;
      while (data_q.size() > 0 && n < 40)
      begin
         @(negedge MCLK);
         n++;
         if (RX_DATA_VALID === 1'b1) note(data_q.pop_front(), RX_DATA);
      end
      if (data_q.size() > 0) timeout();
      @(posedge MCLK);
      {RX_DATA_READY, RX_IRQ_ENABLE, ERR_IRQ_ENABLE} <= 3'b001;
      cyc(3);
      note(8'h02, {6'h00, RX_IRQ_FLAG, RX_READY_OUT});
      strobe(5'b10000);
      for (int f = 0; f < 2; f++)
      begin
         strobe(f == 0 ? 5'b00010 : 5'b00001);
         cyc(3);
         note(8'h03, {5'h00, RX_IRQ_FLAG, ERR_IRQ_FLAG, IRQ});
         strobe(5'b00100);
         cyc(3);
         note(8'h00, {6'h00, ERR_IRQ_FLAG, IRQ});
      end
      cyc(4);
      stop_test();
   end
endmodule
`default_nettype wire
